// *** hdl/output_clock_mute_control.sv ***
`timescale 1ns/1ps
// Output clock mute control with an APB register slave.
// Assumes source_valid and the APB signals are synchronous to mclk.
// How it works
// RULE1: Channel 4 has a two-bit read-write mute level at bits 1:0, reset 1, best set to 3.
// RULE2: In differential mode level 0 bypasses, 1 goes to common mode, 2 forces high, 3 rails.
// RULE3: In single-ended mode level 0 bypasses, 1 pulls N low, 2 pulls P low, 3 pulls both low.
// RULE4: The level only picks the muted state; the auto-mute bit alone decides muting.
// RULE5: Channel n is disabled when its auto-mute bit is 1 and the source is invalid.
// RULE6: A channel whose auto-mute bit is 0 keeps running whatever the source does.
// RULE7: The eight auto-mute bits are read-write, reset to 1 and are nonvolatile settings.
// RULE8: Aux output one mute, bit 1 reset 1, disables it on invalid source when it carries a clock.
// RULE9: Aux output zero mute, bit 0 reset 0, disables it on invalid source when it carries a clock.
// RULE10: An aux output not carrying a clock runs normally whatever its mute bit.
// RULE11: An aux output whose mute bit is 0 keeps running whatever the source does.
// RULE12: Bits 7:2 of the aux mute register are reserved, read zero and are not nonvolatile.
// RULE13: Muting is applied on the clock from one source-valid input so no runt pulse appears.
module output_clock_mute_control
	import mute_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Source detection
	input wire logic source_valid,
	// Channel and auxiliary output controls
	output logic [NUM_CHAN-1:0] chan_disable,
	output logic aux_output_zero_disable,
	output logic aux_output_one_disable,
	output drive_state_t chan4_drive_state,
	// Nonvolatile image of the stored settings
	output logic [7:0] nv_chan_auto_mute,
	output logic [1:0] nv_aux_auto_mute
);
	// ********************
	// Registers
	// ********************
	logic [NUM_CHAN-1:0] output_channel_auto_mute;
	logic [1:0] aux_output_auto_mute;
	logic [1:0] chan4_muted_drive_level;
	logic [2:0] mode_cfg;
	logic [NUM_CHAN-1:0] chan_muted;
	logic [1:0] aux_muted;
	drive_state_t next_chan4_state;

	wire chan0_auto_mute_enable = output_channel_auto_mute[0];
	wire chan3_auto_mute_enable = output_channel_auto_mute[3];
	wire chan7_auto_mute_enable = output_channel_auto_mute[7];
	wire aux_out_one_auto_mute = aux_output_auto_mute[AUX_ONE_BIT];
	wire aux_out_zero_auto_mute = aux_output_auto_mute[AUX_ZERO_BIT];
	wire single_ended = mode_cfg[MODE_SE_BIT];
	wire [1:0] aux_carries_clock = {mode_cfg[MODE_AUX1_CLK_BIT], mode_cfg[MODE_AUX0_CLK_BIT]};

	// ********************
	// Bus decode
	// ********************
	// Zero wait states: the answer comes in the first access cycle.
	function automatic logic addr_hit(input logic [31:0] addr, input logic [7:0] idx);
		addr_hit = addr == byte_addr(idx);
	endfunction

	wire setup_phase = psel && !penable;
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire rd_setup = setup_phase && !pwrite;
	wire hit_chan = addr_hit(paddr, IDX_CHAN_MUTE);
	wire hit_aux = addr_hit(paddr, IDX_AUX_MUTE);
	wire hit_lvl = addr_hit(paddr, IDX_CHAN4_LEVEL);
	wire hit_mode = addr_hit(paddr, IDX_MODE);
	wire hit_stat = addr_hit(paddr, IDX_STATUS);
	wire mapped = hit_chan || hit_aux || hit_lvl || hit_mode || hit_stat;
	wire wr_chan = wr && hit_chan;
	wire wr_aux = wr && hit_aux;
	wire wr_lvl = wr && hit_lvl;
	wire wr_mode = wr && hit_mode;

	// Reserved bits are simply not stored, so they always read back as zero.
	wire [31:0] chan_word = {24'h0, output_channel_auto_mute};
	wire [31:0] aux_word = {30'h0, aux_output_auto_mute}; // [RULE12]
	wire [31:0] lvl_word = {30'h0, chan4_muted_drive_level};
	wire [31:0] mode_word = {29'h0, mode_cfg};
	wire [31:0] status_word = {22'h0, aux_muted, chan_muted};
	wire [31:0] read_mux =
		hit_chan ? chan_word :
		hit_aux ? aux_word :
		hit_lvl ? lvl_word :
		hit_mode ? mode_word :
		hit_stat ? status_word : 32'h0;

	// ********************
	// Register file
	// ********************
	// Writes land at the access edge, the same edge at which the master sees pready high.
	wire [NUM_CHAN-1:0] next_output_channel_auto_mute =
		wr_chan ? pwdata[NUM_CHAN-1:0] : output_channel_auto_mute; // [RULE7]
	wire [1:0] next_aux_output_auto_mute =
		wr_aux ? pwdata[1:0] : aux_output_auto_mute; // [RULE12]
	wire [1:0] next_chan4_muted_drive_level =
		wr_lvl ? pwdata[1:0] : chan4_muted_drive_level; // [RULE1]
	wire [2:0] next_mode_cfg = wr_mode ? pwdata[2:0] : mode_cfg;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			output_channel_auto_mute <= RST_CHAN_MUTE; // [RULE7]
		end
		else
		begin
			output_channel_auto_mute <= next_output_channel_auto_mute; // [RULE7]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			aux_output_auto_mute <= RST_AUX_MUTE; // [RULE8] [RULE9]
		end
		else
		begin
			aux_output_auto_mute <= next_aux_output_auto_mute; // [RULE12]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			chan4_muted_drive_level <= RST_CHAN4_LEVEL; // [RULE1]
		end
		else
		begin
			chan4_muted_drive_level <= next_chan4_muted_drive_level; // [RULE1]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			mode_cfg <= 3'h0;
		end
		else
		begin
			mode_cfg <= next_mode_cfg;
		end
	end

	// ********************
	// Bus response
	// ********************
	// Each answer stands for exactly the one access cycle that follows the setup cycle.
	wire next_pready = setup_phase;
	wire next_pslverr = setup_phase && !mapped;
	wire [31:0] next_prdata = rd_setup ? read_mux : 32'h0;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
		end
		else
		begin
			pready <= next_pready;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pslverr <= 1'b0;
		end
		else
		begin
			pslverr <= next_pslverr;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			prdata <= 32'h0;
		end
		else
		begin
			prdata <= next_prdata;
		end
	end

	// ********************
	// Mute decision
	// ********************
	mute_gate #(.WIDTH(NUM_CHAN)) u_chan_gate
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.enable(output_channel_auto_mute), // [RULE5] [RULE6]
		.eligible({NUM_CHAN{1'b1}}),
		.source_valid(source_valid),
		.muted(chan_muted)
	);

	mute_gate #(.WIDTH(2)) u_aux_gate
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.enable({aux_out_one_auto_mute, aux_out_zero_auto_mute}), // [RULE11]
		.eligible(aux_carries_clock), // [RULE8] [RULE9] [RULE10]
		.source_valid(source_valid),
		.muted(aux_muted)
	);

	drive_level_map u_chan4_map
	(
		.muted(chan_muted[4]),
		.single_ended(single_ended),
		.level(chan4_muted_drive_level),
		.state(next_chan4_state)
	);

	// ********************
	// Nonvolatile image
	// ********************
	// Only the ten mute bits are stored; the reserved aux bits have no storage to copy.
	wire [7:0] next_nv_chan_auto_mute = {chan7_auto_mute_enable,
		output_channel_auto_mute[6:4], chan3_auto_mute_enable,
		output_channel_auto_mute[2:1], chan0_auto_mute_enable}; // [RULE7]
	wire [1:0] next_nv_aux_auto_mute = aux_output_auto_mute; // [RULE12]

	// ********************
	// Outputs
	// ********************
	// Outputs lag the decision by one cycle; every output stays a flip-flop.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			chan_disable <= '0;
		end
		else
		begin
			chan_disable <= chan_muted; // [RULE5]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			aux_output_zero_disable <= 1'b0;
		end
		else
		begin
			aux_output_zero_disable <= aux_muted[AUX_ZERO_BIT]; // [RULE9]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			aux_output_one_disable <= 1'b0;
		end
		else
		begin
			aux_output_one_disable <= aux_muted[AUX_ONE_BIT]; // [RULE8]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			chan4_drive_state <= DRV_NORMAL;
		end
		else
		begin
			chan4_drive_state <= next_chan4_state; // [RULE4]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			nv_chan_auto_mute <= RST_CHAN_MUTE;
		end
		else
		begin
			nv_chan_auto_mute <= next_nv_chan_auto_mute; // [RULE7]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			nv_aux_auto_mute <= RST_AUX_MUTE;
		end
		else
		begin
			nv_aux_auto_mute <= next_nv_aux_auto_mute; // [RULE12]
		end
	end
endmodule

// *** hdl/mute_ctrl_pkg.sv ***
// Constants shared by the output mute control block.
// Assumes a 32-bit APB register bus and an 8-bit register layout inside each word.
package mute_ctrl_pkg;
	localparam int NUM_CHAN = 8;
	// Printed offsets are not multiples of four: they are indices, byte address is four times.
	localparam logic [7:0] IDX_CHAN_MUTE = 8'h16;
	localparam logic [7:0] IDX_AUX_MUTE = 8'h17;
	localparam logic [7:0] IDX_CHAN4_LEVEL = 8'h40;
	localparam logic [7:0] IDX_MODE = 8'h41;
	localparam logic [7:0] IDX_STATUS = 8'h42;
	localparam logic [7:0] RST_CHAN_MUTE = 8'hff;
	localparam logic [1:0] RST_AUX_MUTE = 2'h2;
	localparam logic [1:0] RST_CHAN4_LEVEL = 2'h1;
	localparam int AUX_ONE_BIT = 1;
	localparam int AUX_ZERO_BIT = 0;
	localparam int MODE_SE_BIT = 0;
	localparam int MODE_AUX0_CLK_BIT = 1;
	localparam int MODE_AUX1_CLK_BIT = 2;
	typedef enum logic [1:0]
	{
		LVL_BYPASS = 2'h0,
		LVL_LOW_A = 2'h1,
		LVL_HIGH_B = 2'h2,
		LVL_BOTH = 2'h3
	} mute_level_t;
	// Driver states of one channel, one code per node behaviour.
	typedef enum logic [2:0]
	{
		DRV_NORMAL = 3'h0,
		DRV_VCM = 3'h1,
		DRV_HIGH = 3'h3,
		DRV_RAIL = 3'h2,
		DRV_P_NORM_N_LOW = 3'h6,
		DRV_P_LOW_N_NORM = 3'h7,
		DRV_BOTH_LOW = 3'h5
	} drive_state_t;

	function automatic logic [31:0] byte_addr(input logic [7:0] idx);
		byte_addr = {22'h0, idx, 2'h0};
	endfunction
endpackage

// *** hdl/mute_gate.sv ***
`timescale 1ns/1ps
// Registered mute decision for a group of outputs.
// Assumes the validity input is already synchronous to mclk.
module mute_gate
	import mute_ctrl_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Controls
	input wire logic [WIDTH-1:0] enable,
	input wire logic [WIDTH-1:0] eligible,
	input wire logic source_valid,
	// Result
	output logic [WIDTH-1:0] muted
);
	// Gate updates only on the clock so a change of validity cannot cut a pulse short.
	wire [WIDTH-1:0] next_muted = enable & eligible & {WIDTH{~source_valid}};

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			muted <= '0;
		else
			muted <= next_muted; // [RULE13]
	end
endmodule

// *** hdl/drive_level_map.sv ***
`timescale 1ns/1ps
// Maps a mute level and the output mode onto a driver state.
// Purely combinational; the caller registers the result.
module drive_level_map
	import mute_ctrl_pkg::*;
(
	// Inputs
	input wire logic muted,
	input wire logic single_ended,
	input wire logic [1:0] level,
	// Result
	output drive_state_t state
);
	wire mute_level_t lvl = mute_level_t'(level);
	drive_state_t diff_state;
	drive_state_t se_state;

	always_comb
	begin
		unique case (lvl)
			LVL_BYPASS: diff_state = DRV_NORMAL; // [RULE2]
			LVL_LOW_A: diff_state = DRV_VCM; // [RULE2]
			LVL_HIGH_B: diff_state = DRV_HIGH; // [RULE2]
			LVL_BOTH: diff_state = DRV_RAIL; // [RULE2]
		endcase
	end

	always_comb
	begin
		unique case (lvl)
			LVL_BYPASS: se_state = DRV_NORMAL; // [RULE3]
			LVL_LOW_A: se_state = DRV_P_NORM_N_LOW; // [RULE3]
			LVL_HIGH_B: se_state = DRV_P_LOW_N_NORM; // [RULE3]
			LVL_BOTH: se_state = DRV_BOTH_LOW; // [RULE3]
		endcase
	end

	// The level only shapes the state; whether muting applies comes from the caller.
	assign state = !muted ? DRV_NORMAL : (single_ended ? se_state : diff_state); // [RULE4]
endmodule

// *** bench/mute_ctrl_checker.sv ***
`timescale 1ns/1ps
// Port assertions for the output mute control block.
// Assumes it is bound into the top module and sees its ports only.
module mute_ctrl_checker
	import mute_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bus handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Mute path
	input wire logic source_valid,
	input wire logic [NUM_CHAN-1:0] chan_disable,
	input wire logic aux_output_zero_disable,
	input wire logic aux_output_one_disable,
	input drive_state_t chan4_drive_state,
	input wire logic [7:0] nv_chan_auto_mute,
	input wire logic [1:0] nv_aux_auto_mute
);
	// ***
	// Properties
	// ***
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// The register copy lags one cycle, so it lines up with the two-cycle mute path.
	property p_mute; $past(rst_n) && $past(rst_n, 2) && !$past(source_valid, 2)
		|-> chan_disable == $past(nv_chan_auto_mute); endproperty
	a_mute: assert property (p_mute) else $error("chan mute");
	property p_run; $past(source_valid, 2) |-> chan_disable == 8'h0; endproperty
	a_run: assert property (p_run) else $error("chan run");
	property p_lvl; chan4_drive_state != DRV_NORMAL |-> chan_disable[4]; endproperty
	a_lvl: assert property (p_lvl) else $error("level");
	property p_aux0; aux_output_zero_disable
		|-> $past(nv_aux_auto_mute[0]) && !$past(source_valid, 2); endproperty
	a_aux0: assert property (p_aux0) else $error("aux0");
	property p_aux1; aux_output_one_disable
		|-> $past(nv_aux_auto_mute[1]) && !$past(source_valid, 2); endproperty
	a_aux1: assert property (p_aux1) else $error("aux1");
	property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("slverr");
	property p_edge; $rose(chan_disable[1]) |-> !$past(source_valid, 2); endproperty
	a_edge: assert property (p_edge) else $error("edge");
endmodule

bind output_clock_mute_control mute_ctrl_checker chk_i (.mclk, .rst_n, .psel, .penable,
	.pready, .pslverr, .source_valid, .chan_disable, .aux_output_zero_disable,
	.aux_output_one_disable, .chan4_drive_state, .nv_chan_auto_mute, .nv_aux_auto_mute);

// *** bench/output_clock_mute_control_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the output mute control block.
// Assumes the package, design and checker are compiled first.
module output_clock_mute_control_tb
	import mute_ctrl_pkg::*;
;
	logic mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic source_valid = 1'h1, pready, pslverr, a0, a1, e;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
	logic [7:0] cd, nvc;
	logic [1:0] nva;
	drive_state_t ds;
	int err_total = 0, samples_checked = 0;
	drive_state_t ex[2][4] = '{'{DRV_NORMAL, DRV_VCM, DRV_HIGH, DRV_RAIL},
		'{DRV_NORMAL, DRV_P_NORM_N_LOW, DRV_P_LOW_N_NORM, DRV_BOTH_LOW}};
	output_clock_mute_control dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .source_valid, .chan_disable(cd),
		.aux_output_zero_disable(a0), .aux_output_one_disable(a1), .chan4_drive_state(ds),
		.nv_chan_auto_mute(nvc), .nv_aux_auto_mute(nva));
	initial forever #2 mclk = ~mclk;
	// ***
	// Tasks
	// ***
	task automatic tally_and_finish;
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x)
		begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, g, x);
		end
	endtask
	// The wait is bounded so a missing ready ends the run instead of hanging it.
	task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {22'h0, i, 2'h0};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'h1 && n < 9);
		if (pready !== 1'h1)
		begin
			err_total++;
			tally_and_finish();
		end
		else
		begin
			q = prdata;
			e = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] x);
		bus(1'h0, i, 32'h0);
		chk(q, x);
	endtask
	task automatic sv_wait(input logic v);
		@(posedge mclk);
		source_valid <= v;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	// ***
	// Scenarios
	// ***
	task automatic t_reset;
		rd(IDX_CHAN_MUTE, 32'hff);
		rd(IDX_AUX_MUTE, 32'h2);
		rd(IDX_CHAN4_LEVEL, 32'h1);
		chk(nvc, 32'hff);
		chk(nva, 32'h2);
		rd(8'h30, 32'h0);
		chk(e, 32'h1);
	endtask
	task automatic t_chan;
		bus(1'h1, IDX_CHAN_MUTE, 32'h5a);
		sv_wait(1'h0);
		chk(cd, 32'h5a);
		chk(nvc, 32'h5a);
		rd(IDX_STATUS, 32'h5a);
		sv_wait(1'h1);
		chk(cd, 32'h0);
	endtask
	task automatic t_level;
		for (int s = 0; s < 2; s++)
			for (int l = 0; l < 4; l++)
			begin
				bus(1'h1, IDX_MODE, s);
				bus(1'h1, IDX_CHAN4_LEVEL, l);
				sv_wait(1'h0);
				chk(ds, ex[s][l]);
				chk(cd[4], 32'h1);
			end
		rd(IDX_CHAN4_LEVEL, 32'h3);
		bus(1'h1, IDX_CHAN_MUTE, 32'h0);
		sv_wait(1'h0);
		chk(ds, DRV_NORMAL);
		chk(cd, 32'h0);
	endtask
	task automatic t_aux;
		for (int k = 0; k < 16; k++)
		begin
			bus(1'h1, IDX_AUX_MUTE, 32'hfc | k[3:2]);
			bus(1'h1, IDX_MODE, {k[1:0], 1'h0});
			sv_wait(1'h0);
			chk(a0, k[0] & k[2]);
			chk(a1, k[1] & k[3]);
		end
		rd(IDX_AUX_MUTE, 32'h3);
		chk(nva, 32'h3);
		sv_wait(1'h1);
		chk(a0, 32'h0);
		chk(a1, 32'h0);
	endtask
	// A second reset in mid-run must bring the channel mute and level registers back to their reset values.
	task automatic t_rerun;
		bus(1'h1, IDX_CHAN_MUTE, 32'h0);
		bus(1'h1, IDX_CHAN4_LEVEL, 32'h2);
		@(posedge mclk);
		rst_n <= 1'h0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		sv_wait(1'h0);
		chk(cd, 32'hff);
		chk(ds, DRV_VCM);
		chk(a1, 32'h0);
		rd(IDX_CHAN_MUTE, 32'hff);
		rd(IDX_CHAN4_LEVEL, 32'h1);
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'h1;
		t_reset();
		t_chan();
		t_level();
		t_aux();
		t_rerun();
		tally_and_finish();
	end
endmodule
